/* File: rtl/cmbc_cfg.svh */
// Register offsets, field positions, reset values and layout constants
`ifndef CMBC_CFG_SVH
`define CMBC_CFG_SVH
`define CMBC_OFS_FULL_LO   4'h0
`define CMBC_OFS_FULL_HI   4'h1
`define CMBC_OFS_OVF_LO    4'h2
`define CMBC_OFS_OVF_HI    4'h3
`define CMBC_OFS_PAIR0     4'h4
`define CMBC_OFS_PAIR3     4'h7
`define CMBC_RST_FLAGS     16'h0000
`define CMBC_RST_PAIR      16'h0000
`define CMBC_BIT_DIR       3'd7
`define CMBC_BIT_ABT       3'd6
`define CMBC_BIT_LARB      3'd5
`define CMBC_BIT_ERR       3'd4
`define CMBC_BIT_REQ       3'd3
`define CMBC_BIT_RTREN     3'd2
`define CMBC_SID_MASK      16'h1fff
`define CMBC_EID_MASK      16'h0fff
`define CMBC_DLC_MASK      16'hff1f
`define CMBC_STAT_MASK     16'h1f00
`endif

/* File: rtl/cmbc_pkg.sv */
// Types shared by the message-buffer control block
package cmbc_pkg;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } cmbc_bus_type;
  typedef struct packed {
    logic       stored;
    logic [4:0] buf_idx;
    logic [4:0] hit;
    logic       remote;
  } cmbc_rx_type;
  typedef struct packed {
    logic       done;
    logic       aborted;
    logic       lost_arb;
    logic       bus_err;
    logic [2:0] buf_idx;
  } cmbc_tx_type;
  typedef enum logic [1:0] {CMBC_IDLE, CMBC_OFFER} cmbc_state_type;
endpackage

/* File: rtl/cmbc_top.sv */
// Message-buffer control and status registers of the CAN controller
// Operation
// [RL1] Storing into buffer 16-31 sets its full flag; software clears it.
// [RL2] Storing into a full buffer sets that buffer's overflow flag; software clears it.
// [RL3] Direction bit 1 makes buffer transmit, 0 makes it receive.
// [RL4] Aborted flag is set when the message was aborted.
// [RL5] Lost-arbitration flag is set when arbitration was lost while sending.
// [RL6] Transmit error flag is set on a bus error while sending.
// [RL7] Outcome flags clear whenever the send request becomes set.
// [RL8] Writing 1 requests sending; hardware clears it after success.
// [RL9] Clearing a pending send request asks for an abort.
// [RL10] With auto reply enabled a received remote frame sets send request.
// [RL11] Two-bit priority ranks 11 highest down to 00 lowest.
// [RL12] Each pair register: even buffer in low byte, odd in high byte.
// [RL13] Word one: identifier bits 12-2, SRR bit 1, IDE bit 0, top bits zero.
// [RL14] SRR 1 requests remote transmission, 0 is normal.
// [RL15] IDE 1 sends extended identifier, 0 standard.
// [RL16] Word two holds extended id 17-6; word three bits 15-10 hold 5-0.
// [RL17] Word three bit 9 is the remote request flag.
// [RL18] Software writes zero into reserved bits 8 and 4 of word three.
// [RL19] Length code in bits 3-0 of word three, bits 7-5 read zero.
// [RL20] Eight data bytes, two per word, upper byte is next index.
// [RL21] Receive store records matching filter number in status bits 12-8.
// [RL22] Buffer words live in message RAM, not in this register space.
// [RL23] Full flags of buffers 0-15 sit in a companion register; here they are kept at offset 0 of this block.
// [RL24] Among pending transmit buffers the highest priority is offered first.
`timescale 1ns/100ps
`include "cmbc_cfg.svh"
module cmbc_top #(
  parameter int NUM_TX = 8
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_b_i,
  input  wire cmbc_pkg::cmbc_bus_type bus_i,
  output logic               [15:0] rdata_o,
  input  wire cmbc_pkg::cmbc_rx_type  rx_i,
  input  wire cmbc_pkg::cmbc_tx_type  tx_i,
  input  wire logic                 tx_accept_i,
  output logic                      tx_offer_valid_o,
  output logic                [2:0] tx_offer_idx_o,
  output logic                [7:0] abort_req_o,
  output logic                [7:0] tx_dir_o,
  input  wire logic                 ram_wr_i,
  input  wire logic                 ram_word_sel_i,
  input  wire logic          [15:0] ram_wdata_i,
  input  wire logic           [1:0] ram_kind_i,
  output logic               [15:0] ram_wdata_o,
  output logic                [4:0] ram_hit_o
);
  import cmbc_pkg::*;

  logic        rst_meta;
  logic        rst_sync_b;
  logic [31:0] full_flags;
  logic [31:0] ovf_flags;
  logic [7:0]  ctrl [NUM_TX];
  logic [7:0]  slot_wr;
  logic [7:0]  done_v;
  logic [7:0]  abt_v;
  logic [7:0]  larb_v;
  logic [7:0]  err_v;
  logic [7:0]  rtr_v;
  logic [31:0] store_v;
  logic [31:0] clr_full;
  logic [31:0] clr_ovf;
  logic [15:0] next_rdata;
  logic [2:0]  best_idx;
  logic        best_vld;
  logic [1:0]  best_pri;
  cmbc_state_type state;

  // Reset release through two flops; the first feeds only the second
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // Decode of store events and software clears (write 0 clears a flag)
  always_comb begin
    store_v  = 32'h0;
    clr_full = 32'h0;
    clr_ovf  = 32'h0;
    if (rx_i.stored) store_v[rx_i.buf_idx] = 1'b1;
    if (bus_i.wr && bus_i.addr == `CMBC_OFS_FULL_LO) clr_full[15:0] = ~bus_i.wdata;
    if (bus_i.wr && bus_i.addr == `CMBC_OFS_FULL_HI) clr_full[31:16] = ~bus_i.wdata;
    if (bus_i.wr && bus_i.addr == `CMBC_OFS_OVF_LO) clr_ovf[15:0] = ~bus_i.wdata;
    if (bus_i.wr && bus_i.addr == `CMBC_OFS_OVF_HI) clr_ovf[31:16] = ~bus_i.wdata;
  end

  // Full flags: set wins over a simultaneous software clear
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      full_flags <= {`CMBC_RST_FLAGS, `CMBC_RST_FLAGS};
    end else begin
      full_flags <= (full_flags & ~clr_full) | store_v; // see [RL1] see [RL23]
    end
  end

  // Overflow: a store hitting an already full buffer
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ovf_flags <= {`CMBC_RST_FLAGS, `CMBC_RST_FLAGS};
    end else begin
      ovf_flags <= (ovf_flags & ~clr_ovf) | (store_v & full_flags); // see [RL2]
    end
  end

  // Per-slot event vectors; remote frames only reach slots 0-7
  always_comb begin
    slot_wr = 8'h00;
    done_v  = 8'h00;
    abt_v   = 8'h00;
    larb_v  = 8'h00;
    err_v   = 8'h00;
    rtr_v   = 8'h00;
    for (int p = 0; p < NUM_TX / 2; p++) begin
      if (bus_i.wr && bus_i.addr == `CMBC_OFS_PAIR0 + 4'(p)) begin
        slot_wr[2 * p]     = 1'b1;
        slot_wr[2 * p + 1] = 1'b1;
      end
    end
    done_v[tx_i.buf_idx] = tx_i.done;
    abt_v[tx_i.buf_idx]  = tx_i.aborted;
    larb_v[tx_i.buf_idx] = tx_i.lost_arb;
    err_v[tx_i.buf_idx]  = tx_i.bus_err;
    if (rx_i.stored && rx_i.remote && rx_i.buf_idx < 5'(NUM_TX)) rtr_v[rx_i.buf_idx[2:0]] = 1'b1;
  end

  // One control slot per buffer 0-7; even in low byte, odd in high byte
  for (genvar g = 0; g < NUM_TX; g++) begin : g_slot
    cmbc_tx_slot u_slot (
      .clk_i       (ref_clk_i),
      .rst_b_i     (rst_sync_b),
      .wr_i        (slot_wr[g]),
      .wdata_i     (bus_i.wdata[8 * (g % 2) +: 8]), // see [RL12]
      .done_i      (done_v[g]),
      .abort_i     (abt_v[g]),
      .larb_i      (larb_v[g]),
      .err_i       (err_v[g]),
      .rtr_rx_i    (rtr_v[g]),
      .ctrl_o      (ctrl[g]),
      .abort_req_o (abort_req_o[g])
    );
    assign tx_dir_o[g] = ctrl[g][`CMBC_BIT_DIR];
  end

  // Highest priority pending transmit buffer; lower index wins a tie
  always_comb begin
    best_vld = 1'b0;
    best_idx = 3'h0;
    best_pri = 2'h0;
    for (int i = 0; i < NUM_TX; i++) begin
      if (ctrl[i][`CMBC_BIT_DIR] && ctrl[i][`CMBC_BIT_REQ] &&
          (!best_vld || ctrl[i][1:0] > best_pri)) begin // see [RL24] see [RL11]
        best_vld = 1'b1;
        best_idx = 3'(i);
        best_pri = ctrl[i][1:0];
      end
    end
  end

  // Offer held until the engine accepts; selection may improve meanwhile
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= CMBC_IDLE;
    end else begin
      case (state)
        CMBC_IDLE:  if (best_vld) state <= CMBC_OFFER;
        CMBC_OFFER: if (tx_accept_i || !best_vld) state <= CMBC_IDLE;
        default:    state <= CMBC_IDLE;
      endcase
    end
  end

  // Offer index registered so the engine sees a stable value
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tx_offer_idx_o <= 3'h0;
    end else begin
      tx_offer_idx_o <= best_idx;
    end
  end
  assign tx_offer_valid_o = (state == CMBC_OFFER) && best_vld &&
                            (best_idx == tx_offer_idx_o);

  // Buffer words sit in message RAM; only their layout is enforced here
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ram_wdata_o <= 16'h0000;
      ram_hit_o   <= 5'h00;
    end else if (ram_wr_i) begin
      case (ram_kind_i)
        2'd0:    ram_wdata_o <= ram_wdata_i & `CMBC_SID_MASK; // see [RL13] see [RL14] see [RL15]
        2'd1:    ram_wdata_o <= ram_word_sel_i ? (ram_wdata_i & `CMBC_DLC_MASK) // see [RL17] see [RL19]
                                               : (ram_wdata_i & `CMBC_EID_MASK); // see [RL16]
        2'd2:    ram_wdata_o <= ram_wdata_i; // see [RL20]
        default: ram_wdata_o <= ram_wdata_i & `CMBC_STAT_MASK;
      endcase
    end else if (rx_i.stored) begin
      ram_hit_o   <= rx_i.hit; // see [RL21]
      ram_wdata_o <= {3'b000, rx_i.hit, 8'h00} & `CMBC_STAT_MASK; // see [RL22]
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 16'h0000;
    case (bus_i.addr)
      `CMBC_OFS_FULL_LO: next_rdata = full_flags[15:0];
      `CMBC_OFS_FULL_HI: next_rdata = full_flags[31:16];
      `CMBC_OFS_OVF_LO:  next_rdata = ovf_flags[15:0];
      `CMBC_OFS_OVF_HI:  next_rdata = ovf_flags[31:16];
      default: begin
        for (int p = 0; p < NUM_TX / 2; p++) begin
          if (bus_i.addr == `CMBC_OFS_PAIR0 + 4'(p)) next_rdata = {ctrl[2 * p + 1], ctrl[2 * p]};
        end
      end
    endcase
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= bus_i.rd ? next_rdata : 16'h0000;
    end
  end

  AST_FULL_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b) // see [RL1]
    rx_i.stored |=> full_flags[$past(rx_i.buf_idx)])
    else $error("full flag not set by store");
  AST_OVF_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b) // see [RL2]
    (rx_i.stored && full_flags[rx_i.buf_idx]) |=> ovf_flags[$past(rx_i.buf_idx)])
    else $error("overflow flag not set");
  AST_NO_OVF_EMPTY: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b) // see [RL2]
    (ovf_flags == 32'h0 && !rx_i.stored) |=> ovf_flags == 32'h0)
    else $error("overflow flag rose without store");
  AST_OFFER_PRIO: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b) // see [RL24]
    tx_offer_valid_o |-> ctrl[tx_offer_idx_o][1:0] == best_pri)
    else $error("offered buffer not of highest priority");
  AST_OFFER_TX: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b) // see [RL3]
    tx_offer_valid_o |-> ctrl[tx_offer_idx_o][`CMBC_BIT_DIR] && ctrl[tx_offer_idx_o][`CMBC_BIT_REQ])
    else $error("offered buffer is not a pending transmit");
  AST_SID_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b) // see [RL13]
    (ram_wr_i && ram_kind_i == 2'd0) |=> ram_wdata_o[15:13] == 3'b000)
    else $error("identifier word upper bits not zero");
  AST_HIT_KEPT: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b) // see [RL21]
    (rx_i.stored && !ram_wr_i) |=> ram_hit_o == $past(rx_i.hit) ##1 ram_hit_o == $past(rx_i.hit, 2) || $past(rx_i.stored))
    else $error("filter hit code not recorded");
  AST_RDATA_ONE: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
    !bus_i.rd |=> rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  CVR_OVF: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_b) ovf_flags != 32'h0);
  CVR_OFFER: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_b) tx_offer_valid_o && tx_accept_i);
  CVR_ABORT: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_b) abort_req_o != 8'h00);
endmodule

/* File: rtl/cmbc_tx_slot.sv */
// One transmit/receive slot: control byte of one buffer
`timescale 1ns/100ps
`include "cmbc_cfg.svh"
module cmbc_tx_slot (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       done_i,
  input  wire logic       abort_i,
  input  wire logic       larb_i,
  input  wire logic       err_i,
  input  wire logic       rtr_rx_i,
  output logic      [7:0] ctrl_o,
  output logic            abort_req_o
);
  logic [7:0] ctrl;
  logic       set_req;
  assign set_req = (wr_i && wdata_i[`CMBC_BIT_REQ] && !ctrl[`CMBC_BIT_REQ])
                 || (rtr_rx_i && ctrl[`CMBC_BIT_RTREN] && !ctrl[`CMBC_BIT_REQ]); // see [RL10]
  // Abort request pulse when software drops a pending request
  assign abort_req_o = wr_i && ctrl[`CMBC_BIT_REQ] && !wdata_i[`CMBC_BIT_REQ]; // see [RL9]
  assign ctrl_o = ctrl;

  // Writable fields and hardware outcome flags
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl <= 8'h00;
    end else begin
      if (wr_i) begin
        ctrl[`CMBC_BIT_DIR]   <= wdata_i[`CMBC_BIT_DIR]; // see [RL3]
        ctrl[`CMBC_BIT_RTREN] <= wdata_i[`CMBC_BIT_RTREN];
        ctrl[1:0]             <= wdata_i[1:0]; // see [RL11]
        ctrl[`CMBC_BIT_REQ]   <= wdata_i[`CMBC_BIT_REQ]; // see [RL8]
      end
      if (done_i) ctrl[`CMBC_BIT_REQ] <= 1'b0; // see [RL8]
      if (abort_i) begin
        ctrl[`CMBC_BIT_ABT] <= 1'b1; // see [RL4]
        ctrl[`CMBC_BIT_REQ] <= 1'b0;
      end
      if (larb_i) ctrl[`CMBC_BIT_LARB] <= 1'b1; // see [RL5]
      if (err_i) ctrl[`CMBC_BIT_ERR] <= 1'b1; // see [RL6]
      if (set_req) begin
        ctrl[`CMBC_BIT_REQ]  <= 1'b1;
        ctrl[`CMBC_BIT_ABT]  <= 1'b0; // see [RL7]
        ctrl[`CMBC_BIT_LARB] <= 1'b0;
        ctrl[`CMBC_BIT_ERR]  <= 1'b0;
      end
    end
  end

  AST_FLAGS_CLEAR_ON_REQ: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RL7]
    set_req |=> (ctrl[6:4] == 3'b000 && ctrl[`CMBC_BIT_REQ]))
    else $error("outcome flags not cleared on new send request");
  AST_DONE_CLEARS_REQ: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RL8]
    (done_i && !set_req) |=> !ctrl[`CMBC_BIT_REQ])
    else $error("send request not cleared after completion");
  AST_ABORT_SETS_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RL4]
    (abort_i && !set_req) |=> (ctrl[`CMBC_BIT_ABT] && !ctrl[`CMBC_BIT_REQ]))
    else $error("aborted flag not set");
  AST_RTR_NO_ARM: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see [RL10]
    (rtr_rx_i && !ctrl[`CMBC_BIT_RTREN] && !wr_i && !ctrl[`CMBC_BIT_REQ]) |=> !ctrl[`CMBC_BIT_REQ])
    else $error("remote frame armed request while reply disabled");
endmodule

/* File: tb/cmbc_engine_model.sv */
// Behavioural model of the CAN protocol engine beside the buffer control
`timescale 1ns/100ps
module cmbc_engine_model (
  input  wire logic             clk_i,
  input  wire logic             offer_valid_i,
  input  wire logic       [3:0] accept_delay_i,
  output cmbc_pkg::cmbc_rx_type rx_o,
  output cmbc_pkg::cmbc_tx_type tx_o,
  output logic                  accept_o
);
  import cmbc_pkg::*;

  // Takes an offer after a chosen delay; a long delay mimics a busy bus
  initial begin
    rx_o = '0;
    tx_o = '0;
    accept_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (offer_valid_i === 1'b1) begin
        repeat (accept_delay_i) @(posedge clk_i);
        accept_o <= offer_valid_i;
        @(posedge clk_i);
        accept_o <= 1'b0;
      end
    end
  end

  // Stores a frame; idle fields are inverted so stale values never match
  task automatic store(input logic [4:0] idx, input logic [4:0] hit, input logic rem);
    @(posedge clk_i);
    rx_o <= {1'b1, idx, hit, rem};
    @(posedge clk_i);
    rx_o <= {1'b0, ~idx, ~hit, ~rem};
  endtask

  // Outcome of a send: 0 done, 1 aborted, 2 lost arbitration, 3 bus error
  task automatic finish(input logic [2:0] idx, input logic [1:0] code);
    @(posedge clk_i);
    tx_o <= {code == 2'd0, code == 2'd1, code == 2'd2, code == 2'd3, idx};
    @(posedge clk_i);
    tx_o <= {4'b0000, ~idx};
  endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the message-buffer control block
`timescale 1ns/100ps
module testbench;
  import cmbc_pkg::*;
  logic         ref_clk_i;
  logic         rst_b_i;
  cmbc_bus_type bus;
  cmbc_rx_type  rx;
  cmbc_tx_type  tx;
  logic         accept;
  logic         offer_valid;
  logic [2:0]   offer_idx;
  logic [7:0]   abort_req;
  logic [7:0]   tx_dir;
  logic [7:0]   last_abort;
  logic         ram_wr;
  logic         ram_sel;
  logic [1:0]   ram_kind;
  logic [15:0]  ram_in;
  logic [15:0]  ram_out;
  logic [15:0]  rdata;
  logic [4:0]   ram_hit;
  logic [3:0]   acc_dly;
  int           bad_count;
  int           cmp_count;

  cmbc_top uut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata),
    .rx_i(rx), .tx_i(tx), .tx_accept_i(accept), .tx_offer_valid_o(offer_valid),
    .tx_offer_idx_o(offer_idx), .abort_req_o(abort_req), .tx_dir_o(tx_dir),
    .ram_wr_i(ram_wr), .ram_word_sel_i(ram_sel), .ram_wdata_i(ram_in),
    .ram_kind_i(ram_kind), .ram_wdata_o(ram_out), .ram_hit_o(ram_hit)
  );
  cmbc_engine_model eng (
    .clk_i(ref_clk_i), .offer_valid_i(offer_valid), .accept_delay_i(acc_dly),
    .rx_o(rx), .tx_o(tx), .accept_o(accept)
  );

  // Clock at 40 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic give_verdict();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle write; the abort pulse is caught while the strobe is up
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    bus <= {a, d, 1'b1, 1'b0};
    #1 last_abort = abort_req;
    @(posedge ref_clk_i);
    bus <= '0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    bus <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    bus <= '0;
    #1 chk("rdata", exp, rdata);
  endtask

  // Bounded wait; the extra edges let a finished slot drop its offer first
  task automatic wait_offer();
    repeat (3) @(posedge ref_clk_i);
    for (int n = 0; n < 40 && offer_valid !== 1'b1; n++) @(posedge ref_clk_i);
    #1 chk("offer_valid", 16'h0001, {15'h0000, offer_valid});
  endtask

  task automatic t_reset_values();
    for (int a = 0; a < 9; a++) rd_chk(a[3:0], 16'h0000);
    wr_reg(4'h9, 16'hffff);
    rd_chk(4'h9, 16'h0000);
  endtask

  task automatic t_rx_flags();
    eng.store(5'd3, 5'd7, 1'b0);
    #1 chk("ram_hit", 16'h0007, {11'h000, ram_hit});
    eng.store(5'd20, 5'd12, 1'b0);
    eng.store(5'd20, 5'd12, 1'b0);
    rd_chk(4'h0, 16'h0008);
    rd_chk(4'h1, 16'h0010);
    rd_chk(4'h3, 16'h0010);
    rd_chk(4'h2, 16'h0000);
    wr_reg(4'h1, 16'hffef);
    wr_reg(4'h3, 16'hffef);
    wr_reg(4'h0, 16'h0000);
    rd_chk(4'h1, 16'h0000);
    rd_chk(4'h3, 16'h0000);
    rd_chk(4'h0, 16'h0000);
  endtask

  // Four priorities pending at once must leave in the order 3, 7, 2, 6
  task automatic t_priority();
    logic [2:0] order [4];
    order = '{3'd3, 3'd7, 3'd2, 3'd6};
    acc_dly <= 4'd3;
    wr_reg(4'h5, 16'hfbf9);
    wr_reg(4'h7, 16'h8a88);
    rd_chk(4'h5, 16'h8b89);
    chk("tx_dir", 16'h00cc, {8'h00, tx_dir});
    for (int i = 0; i < 4; i++) begin
      wait_offer();
      chk("offer_idx", {13'h0000, order[i]}, {13'h0000, offer_idx});
      eng.finish(order[i], 2'd0);
    end
    rd_chk(4'h5, 16'h8381);
    rd_chk(4'h7, 16'h8280);
  endtask

  task automatic t_abort();
    acc_dly <= 4'd0;
    wr_reg(4'h5, 16'h8389);
    wr_reg(4'h5, 16'h8381);
    chk("abort_req", 16'h0004, {8'h00, last_abort});
    eng.finish(3'd2, 2'd1);
    rd_chk(4'h5, 16'h83c1);
    eng.finish(3'd2, 2'd2);
    rd_chk(4'h5, 16'h83e1);
    eng.finish(3'd2, 2'd3);
    rd_chk(4'h5, 16'h83f1);
    wr_reg(4'h5, 16'h8389);
    rd_chk(4'h5, 16'h8389);
    eng.finish(3'd2, 2'd0);
    rd_chk(4'h5, 16'h8381);
  endtask

  task automatic t_remote();
    wr_reg(4'h6, 16'h8084);
    eng.store(5'd4, 5'd1, 1'b1);
    eng.store(5'd5, 5'd2, 1'b1);
    rd_chk(4'h6, 16'h808c);
  endtask

  // Layout masks; the length word reads bits 7-5 as zero
  task automatic t_ram();
    logic [1:0]  kind [5];
    logic [15:0] din  [5];
    logic [15:0] exp  [5];
    kind = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd3};
    din  = '{16'hffff, 16'hffff, 16'hfeef, 16'ha55a, 16'hffff};
    exp  = '{16'h1fff, 16'h0fff, 16'hfe0f, 16'ha55a, 16'h1f00};
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk_i);
      ram_wr <= 1'b1;
      ram_kind <= kind[i];
      ram_sel <= (i == 2);
      ram_in <= din[i];
      @(posedge ref_clk_i);
      ram_wr <= 1'b0;
      #1 chk("ram_wdata", exp[i], ram_out);
    end
  endtask

  // Watchdog reckoned at more than twenty times the expected run length
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    bad_count++;
    give_verdict();
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    rst_b_i = 1'b0;
    bus = '0;
    ram_wr = 1'b0;
    ram_sel = 1'b0;
    ram_kind = 2'd0;
    ram_in = 16'h0000;
    acc_dly = 4'd0;
    last_abort = 8'h00;
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_reset_values();
    t_rx_flags();
    t_priority();
    t_abort();
    t_remote();
    t_ram();
    give_verdict();
  end
endmodule
